// File: hdl/fsr_host.sv
`include "fsr_params.svh"
module fsr_host #(
  parameter int RST_DONE_CYC = `FSR_RST_DONE_CYC,
  parameter int WAKE_CYC     = `FSR_WAKE_CYC
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  // User side
  input  wire logic             i_req_valid,
  input  wire fsr_pkg::fsr_req_t i_req,
  output logic                  o_req_ready,
  output logic                  o_rsp_valid,
  output fsr_pkg::fsr_rsp_t     o_rsp,
  // Flash pins
  output logic [19:0]           o_addr,
  input  wire logic [7:0]       i_dq,
  output logic [7:0]            o_dq,
  output logic                  o_dq_oe,
  output logic                  o_ce_n,
  output logic                  o_oe_n,
  output logic                  o_we_n,
  output logic                  o_reset_n,
  input  wire logic             i_ready_busy_n_output
);
  localparam int RST_LOW_CYC = `FSR_RST_LOW_CYC;
  localparam int CW = 16;

  // Elaboration check: counts must fit the counter and cover the pulse minimum
  if (RST_DONE_CYC < RST_LOW_CYC || RST_DONE_CYC >= (1 << CW) || WAKE_CYC < 1 ||
      WAKE_CYC >= (1 << CW)) begin : g_bad_counts
    $error("fsr_host: reset counts out of range");
  end

  typedef enum logic [3:0] {
    FSR_IDLE, FSR_SETUP, FSR_STROBE, FSR_HOLD, FSR_GAP, FSR_RST_LOW, FSR_WAKE
  } fsr_state_t;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] dq_s;
  logic       rb_n_s;

  fsr_sync #(.WIDTH(9)) u_sync (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    ({i_ready_busy_n_output, i_dq}),
    .o_sync     ({rb_n_s, dq_s})
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  fsr_state_t        state;
  fsr_state_t        next_state;
  logic [CW-1:0]     cnt;
  logic [CW-1:0]     next_cnt;
  fsr_pkg::fsr_req_t cur;
  fsr_pkg::fsr_req_t next_cur;
  logic [7:0]        first;
  logic [7:0]        next_first;
  logic              second;
  logic              next_second;
  logic              rsp_valid;
  logic              next_rsp_valid;
  fsr_pkg::fsr_rsp_t rsp;
  fsr_pkg::fsr_rsp_t next_rsp;
  logic              rst_n;
  logic              next_rst_n;

  // Cycle count to counter load: count minus one, cast to the counter width
  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n - 1);
  endfunction

  // Two reads differ in a bit only while that bit is toggling
  function automatic logic differs(input logic [7:0] a, input logic [7:0] b, input int pos);
    differs = a[pos] ^ b[pos];
  endfunction

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_cur       = cur;
    next_first     = first;
    next_second    = second;
    next_rsp_valid = 1'b0;
    next_rsp       = rsp;
    next_rst_n     = rst_n;
    unique case (state)
      FSR_IDLE: begin
        if (i_req_valid) begin
          next_cur    = i_req;
          next_second = 1'b0;
          if (i_req.cmd == `FSR_CMD_RESET) begin
            next_rst_n  = 1'b0;
            next_cnt    = cyc(RST_DONE_CYC);
            next_state  = FSR_RST_LOW;
          end else begin
            next_cnt   = cyc(`FSR_SETUP_CYC);
            next_state = FSR_SETUP;
          end
        end
      end
      FSR_SETUP: begin
        if (cnt == '0) begin
          next_cnt   = cyc(`FSR_STROBE_CYC);
          next_state = FSR_STROBE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      FSR_STROBE: begin
        if (cnt == '0) begin
          next_cnt   = cyc(`FSR_HOLD_CYC);
          next_state = FSR_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      FSR_HOLD: begin
        if (cnt == '0) begin
          next_state = FSR_IDLE;
          if (cur.cmd == `FSR_CMD_WRITE) begin
            // Status sent after the rising write strobe; busy is the pin as sampled at the edge that raised it
            next_rsp_valid = 1'b1;
            next_rsp.busy  = ~rb_n_s;
            next_rsp.data  = cur.data;
          end else if (cur.cmd == `FSR_CMD_POLL && !second) begin
            // Second full strobe cycle advances toggle bits
            next_first  = dq_s;
            next_second = 1'b1;
            next_cnt    = cyc(`FSR_SETUP_CYC);
            next_state  = FSR_GAP;
          end else begin
            next_rsp_valid             = 1'b1;
            next_rsp.data              = dq_s;
            next_rsp.toggling          = (cur.cmd == `FSR_CMD_POLL) &&
                                         differs(first, dq_s, `FSR_BIT_TOGGLE);
            // Sector toggle shows erasing or suspended sector
            next_rsp.sector_toggling   = (cur.cmd == `FSR_CMD_POLL) &&
                                         differs(first, dq_s, `FSR_BIT_SECTOR);
            // Failure seen only while still toggling
            next_rsp.fail              = next_rsp.toggling && dq_s[`FSR_BIT_FAIL];
            next_rsp.window_closed     = dq_s[`FSR_BIT_WINDOW];
            next_rsp.busy              = ~rb_n_s;
          end
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      FSR_GAP: begin
        // Chip select released between the two status reads
        if (cnt == '0) begin
          next_cnt   = cyc(`FSR_SETUP_CYC);
          next_state = FSR_SETUP;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      FSR_RST_LOW: begin
        // Hold reset through the abort time
        if (cnt == '0) begin
          next_rst_n = 1'b1;
          next_cnt   = cyc(WAKE_CYC);
          next_state = FSR_WAKE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      FSR_WAKE: begin
        // No read before wake-up time has passed
        if (cnt == '0) begin
          next_rsp_valid = 1'b1;
          next_rsp       = '0;
          next_rsp.busy  = ~rb_n_s;
          next_state     = FSR_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = FSR_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= FSR_IDLE;
      cnt       <= '0;
      cur       <= '0;
      first     <= '0;
      second    <= 1'b0;
      rsp_valid <= 1'b0;
      rsp       <= '0;
      rst_n     <= 1'b1;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      cur       <= next_cur;
      first     <= next_first;
      second    <= next_second;
      rsp_valid <= next_rsp_valid;
      rsp       <= next_rsp;
      rst_n     <= next_rst_n;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  logic active;
  logic is_wr;

  // Strobes follow state; write data driven only in write cycles
  always_comb begin
    active    = (state == FSR_SETUP) || (state == FSR_STROBE) || (state == FSR_HOLD);
    is_wr     = (cur.cmd == `FSR_CMD_WRITE);
    o_ce_n    = ~active;
    o_oe_n    = ~(active && !is_wr && state != FSR_SETUP);
    o_we_n    = ~(state == FSR_STROBE && is_wr);
    // Never drive the bus around reset
    o_dq_oe   = active && is_wr && rst_n;
    o_dq      = cur.data;
    o_addr    = cur.addr;
    o_reset_n = rst_n;
  end

  assign o_req_ready = (state == FSR_IDLE);
  assign o_rsp_valid = rsp_valid;
  assign o_rsp       = rsp;
endmodule

// File: hdl/fsr_params.svh
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH
// Clock rate in kHz
`define FSR_CLK_KHZ           20000
// Reset pulse least width, ns
`define FSR_RST_LOW_NS        500
// Reset completion time, us
`define FSR_RST_DONE_US       20
// Wake-up time after reset release, ns
`define FSR_WAKE_NS           1000
// Strobe phase lengths in cycles
`define FSR_SETUP_CYC         2
`define FSR_STROBE_CYC        3
`define FSR_HOLD_CYC          2
// Derived cycle counts, rounded up
`define FSR_RST_LOW_CYC  ((`FSR_RST_LOW_NS * `FSR_CLK_KHZ + 999999) / 1000000)
`define FSR_RST_DONE_CYC ((`FSR_RST_DONE_US * `FSR_CLK_KHZ + 999) / 1000)
`define FSR_WAKE_CYC     ((`FSR_WAKE_NS * `FSR_CLK_KHZ + 999999) / 1000000)
// Status bit positions
`define FSR_BIT_POLL          7
`define FSR_BIT_TOGGLE        6
`define FSR_BIT_FAIL          5
`define FSR_BIT_WINDOW        3
`define FSR_BIT_SECTOR        2
// Command codes on the user port
`define FSR_CMD_READ          2'h0
`define FSR_CMD_WRITE         2'h1
`define FSR_CMD_POLL          2'h2
`define FSR_CMD_RESET         2'h3
`endif

// File: hdl/fsr_pkg.sv
package fsr_pkg;
  typedef struct packed {
    logic [1:0]  cmd;
    logic [19:0] addr;
    logic [7:0]  data;
  } fsr_req_t;

  typedef struct packed {
    logic       toggling;
    logic       sector_toggling;
    logic       fail;
    logic       window_closed;
    logic       busy;
    logic [7:0] data;
  } fsr_rsp_t;
endpackage

// File: hdl/fsr_sync.sv
module fsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // Two-stage synchroniser; first stage feeds only the second
  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end
endmodule

// File: verification/fsr_host_monitor.sv
module fsr_host_monitor #(
  parameter int RST_DONE_CYC = 400,
  parameter int WAKE_CYC     = 20
) (
  input wire logic              i_core_clk,
  input wire logic              i_nrst,
  input wire logic              i_req_valid,
  input wire fsr_pkg::fsr_req_t i_req,
  input wire logic              o_req_ready,
  input wire logic              o_rsp_valid,
  input wire logic              o_reset_n,
  input wire logic              o_oe_n,
  input wire logic              o_ce_n,
  input wire logic              o_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int lo_cnt;
  int hi_cnt;
  int next_lo_cnt;
  int next_hi_cnt;
  // Pulse and wake counters; wake saturates so it cannot wrap
  always_comb begin
    next_lo_cnt = o_reset_n ? 0 : lo_cnt + 1;
    next_hi_cnt = !o_reset_n ? 0 : (hi_cnt < 999) ? hi_cnt + 1 : hi_cnt;
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lo_cnt <= 0;
      hi_cnt <= 999;
    end else begin
      lo_cnt <= next_lo_cnt;
      hi_cnt <= next_hi_cnt;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_pulse_width: assert property ($rose(o_reset_n) |-> lo_cnt >= RST_DONE_CYC)
    else $error("reset pulse too short");
  a_wake_wait: assert property (!o_oe_n |-> hi_cnt >= WAKE_CYC)
    else $error("read before wake-up");
  a_reset_quiet: assert property (!o_reset_n |-> o_ce_n && o_oe_n && !o_dq_oe)
    else $error("bus active during reset");
  a_read_latency: assert property (
    i_req_valid && o_req_ready && i_req.cmd == 2'h0 |-> ##1 !o_rsp_valid [*6] ##[1:2] o_rsp_valid)
    else $error("read answer late");
  a_reset_start: assert property (
    i_req_valid && o_req_ready && i_req.cmd == 2'h3 |-> ##[1:2] !o_reset_n)
    else $error("reset pin not driven");
  c_reset: cover property ($rose(o_reset_n));
  c_answer: cover property (o_rsp_valid);
  c_read: cover property (!o_oe_n && !o_ce_n);
endmodule

bind fsr_host fsr_host_monitor #(.RST_DONE_CYC(RST_DONE_CYC), .WAKE_CYC(WAKE_CYC)) u_mon (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req(i_req),
  .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_reset_n(o_reset_n),
  .o_oe_n(o_oe_n), .o_ce_n(o_ce_n), .o_dq_oe(o_dq_oe));

// File: verification/fsr_flash_model.sv
module fsr_flash_model (
  input  wire logic [19:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_dq_oe,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_reset_n,
  output logic      [7:0]  o_dq,
  output logic             o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sector that refuses program and erase
  localparam int PROT = 15;
  logic [7:0] mem [16];
  logic [7:0] last, prog, stat;
  logic       tog = 1'b0, fail = 1'b0, ers = 1'b0, lock = 1'b0, sus = 1'b0;
  int         bcnt = 0, wcnt = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // 100 ns steps, lock ends only at reset
  always #100 begin
    if (lock && bcnt == 1) fail = 1'b1;
    else if (bcnt > 0 && !sus) bcnt--;
  end
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_dq_oe && i_reset_n) begin
      if (ers && bcnt > 0 && !sus && i_dq == 8'hB0) begin
        sus = 1'b1;
        tog = ~tog;
      end else if (sus && i_dq == 8'h30) begin
        sus = 1'b0;
        tog = ~tog;
      end else if (bcnt == 0) begin
        wcnt++;
        if (wcnt == 3) prog = i_dq;
        if (wcnt == 4 && prog == 8'hA0) begin
          lock = |(i_dq & ~mem[i_addr[3:0]]);
          if (!lock && i_addr[3:0] != PROT) mem[i_addr[3:0]] = i_dq;
          prog = i_dq;
          ers = 1'b0;
          bcnt = 20;
          wcnt = 0;
        end else if (wcnt == 6) begin
          foreach (mem[i]) if (i != PROT) mem[i] = 8'hFF;
          ers = 1'b1;
          bcnt = 100;
          wcnt = 0;
        end
      end
    end
  end
  // Status byte, window closes 2 us in
  always_comb begin
    stat = {ers ? 1'b0 : ~prog[7], tog, fail, 1'b0, ers && bcnt < 80, ers ? tog : 1'b1, 2'h0};
    if (sus) stat[7:6] = 2'b11;
  end
  always @(negedge i_oe_n) if (!i_ce_n && bcnt > 0) tog = ~tog;
  always_comb begin
    if (!i_oe_n && !i_ce_n && i_reset_n) begin
      o_dq = (bcnt > 0) ? stat : mem[i_addr[3:0]];
      last = o_dq;
    end else begin
      o_dq = ~last;
    end
  end
  always @(negedge i_reset_n) begin
    bcnt = 0;
    wcnt = 0;
    fail = 1'b0;
    lock = 1'b0;
    sus  = 1'b0;
  end
  assign o_ready_busy_n = ((bcnt > 0 && !sus) || !i_reset_n) ? 1'b0 : 1'b1;
endmodule

// File: verification/fsr_host_tb.sv
module fsr_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0, nrst = 1'b0, valid = 1'b0;
  logic              rdy, rv, dq_oe, ce_n, oe_n, we_n, rst_n, rb_n;
  logic [19:0]       addr, a;
  logic [7:0]        dout, din, d;
  logic [31:0]       seed = 32'd17;
  logic [7:0]        seq [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30};
  fsr_pkg::fsr_req_t req = '0;
  fsr_pkg::fsr_rsp_t rsp;
  int                exp_mem [16];
  int                fail_count = 0;
  int                comparisons = 0;
  always #25 clk = ~clk;
  fsr_host #(.RST_DONE_CYC(20), .WAKE_CYC(2)) i_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_req_valid(valid), .i_req(req), .o_req_ready(rdy),
    .o_rsp_valid(rv), .o_rsp(rsp), .o_addr(addr), .i_dq(din), .o_dq(dout), .o_dq_oe(dq_oe),
    .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_reset_n(rst_n), .i_ready_busy_n_output(rb_n));
  fsr_flash_model i_flash (
    .i_addr(addr), .i_dq(dout), .i_dq_oe(dq_oe), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_reset_n(rst_n), .o_dq(din), .o_ready_busy_n(rb_n));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  // Request held until taken, answer awaited under a bound
  task automatic op(input logic [1:0] c, input logic [19:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    @(negedge clk);
    req = '{cmd: c, addr: ad, data: dt};
    valid = 1'b1;
    // Ready is settled at the falling edge and holds to the taking edge
    while (rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
    while (rv !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, rv}, 8'h01, "answer");
  endtask
  // Unlock pair, then program (4 writes) or erase (6 writes)
  task automatic cmdseq(input int k, input logic [19:0] ad, input logic [7:0] dt);
    for (int i = 0; i < k - 1; i++) begin
      op(2'h1, (i % 2) ? 20'h002AA : 20'h00555, (k == 4 && i == 2) ? 8'hA0 : seq[i]);
    end
    op(2'h1, ad, dt);
  endtask
  // Flags in order toggling, sector, fail, window
  task automatic poll(input logic [19:0] ad, input logic [3:0] e, input logic [3:0] m);
    op(2'h2, ad, 8'h00);
    chk({4'h0, m & {rsp.toggling, rsp.sector_toggling, rsp.fail, rsp.window_closed}},
        {4'h0, e}, "status");
  endtask
  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Scenarios need about 1200 cycles; five times that is a hang
  initial begin
    #300000;
    fail_count++;
    final_report();
  end
  initial begin
    foreach (exp_mem[i]) exp_mem[i] = 255;
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    // Program three places: busy polls toggle, then data reads back
    for (int i = 0; i < 3; i++) begin
      a = {4'h0, rnd(), rnd()};
      a[3:0] = i[3:0];
      d = rnd() & 8'hFE;
      cmdseq(4, a, d);
      poll(a, 4'b1000, 4'b1110);
      chk({7'h0, rsp.busy}, 8'h01, "busy");
      chk({7'h0, rsp.data[7]}, {7'h0, ~d[7]}, "poll bit");
      repeat (50) @(posedge clk);
      poll(a, 4'b0000, 4'b1110);
      exp_mem[i] = d;
      op(2'h0, a, 8'h00);
      chk(rsp.data, 8'(exp_mem[i]), "data");
    end
    // The protected place toggles for a while and keeps its old value
    a[3:0] = 4'hF;
    cmdseq(4, a, d);
    poll(a, 4'b1000, 4'b1110);
    repeat (50) @(posedge clk);
    op(2'h0, a, 8'h00);
    chk(rsp.data, 8'(exp_mem[15]), "protected");
    // One over zero locks; the failure shows and only a reset recovers
    a[3:0] = 4'h2;
    cmdseq(4, a, ~d);
    repeat (80) @(posedge clk);
    poll(a, 4'b1010, 4'b1110);
    op(2'h3, a, 8'h00);
    poll(a ^ 20'h1, 4'b0000, 4'b1110);
    // Erase: window open, then closed; a program meanwhile is refused
    cmdseq(6, a, 8'h30);
    poll(a, 4'b1100, 4'b1111);
    repeat (60) @(posedge clk);
    poll(a, 4'b1101, 4'b1111);
    cmdseq(4, a ^ 20'h1, 8'h00);
    // Suspend frees the busy pin and pins the toggle bit at 1
    op(2'h1, a, 8'hB0);
    poll(a, 4'b0101, 4'b1111);
    chk({6'h0, rsp.data[7:6]}, 8'h03, "suspend poll");
    chk({7'h0, rsp.busy}, 8'h00, "suspend busy");
    op(2'h1, a, 8'h30);
    repeat (200) @(posedge clk);
    foreach (exp_mem[i]) exp_mem[i] = 255;
    for (int i = 0; i < 4; i++) begin
      a[3:0] = i[3:0];
      op(2'h0, a, 8'h00);
      chk(rsp.data, 8'(exp_mem[i]), "erased");
    end
    final_report();
  end
endmodule
